// ==== src/pif_irq_flags.sv ====
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "pif_defines.svh"
module pif_irq_flags #(
    parameter bit HAS_CMPB = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic nvm_write_done,
    input wire logic crypto_done,
    input wire logic timer_wrap,
    input wire logic low_supply_detector,
    input wire logic osc_fail,
    input wire logic comparator_a_result,
    input wire logic comparator_b_result,
    output logic periph_irq
);
    localparam logic [7:0] IMPL = HAS_CMPB ? `PIF_IMPL_MASK : (`PIF_IMPL_MASK & ~`PIF_CMPB_MASK);

    pif_pkg::pif_byte_t enable_ff;
    pif_pkg::pif_byte_t flags_ff;
    pif_pkg::pif_byte_t ctrl_ff;
    pif_pkg::pif_byte_t nxt_enable;
    pif_pkg::pif_byte_t nxt_flags;
    pif_pkg::pif_byte_t nxt_ctrl;
    pif_pkg::pif_byte_t set_vec;
    pif_pkg::pif_byte_t rd_byte;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic irq_ff;
    logic nxt_irq;

    // Pin-side sources pass the three-stage synchroniser
    logic lowv_rise;
    logic osc_rise;
    logic cmpa_chg;
    logic cmpb_chg;
    logic lowv_lvl;
    logic osc_lvl;
    logic cmpa_lvl;
    logic cmpb_lvl;

    pif_event_sync u_sync_lowv (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(low_supply_detector),
        .level_out(lowv_lvl),
        .rise_out(lowv_rise),
        .change_out()
    );
    pif_event_sync u_sync_osc (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(osc_fail),
        .level_out(osc_lvl),
        .rise_out(osc_rise),
        .change_out()
    );
    pif_event_sync u_sync_cmpa (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(comparator_a_result),
        .level_out(cmpa_lvl),
        .rise_out(),
        .change_out(cmpa_chg)
    );
    pif_event_sync u_sync_cmpb (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(comparator_b_result),
        .level_out(cmpb_lvl),
        .rise_out(),
        .change_out(cmpb_chg)
    );

    // APB decode; zero-wait slave, write lands in the access cycle
    wire acc = psel & penable;
    wire wr_en = acc & pwrite;
    wire hit_en = (paddr == `PIF_ADDR_ENABLE);
    wire hit_fl = (paddr == `PIF_ADDR_FLAGS);
    wire hit_ct = (paddr == `PIF_ADDR_CTRL);
    wire hit_st = (paddr == `PIF_ADDR_STATUS);
    wire mapped = hit_en | hit_fl | hit_ct | hit_st;
    wire status_ro = hit_st & pwrite;
    wire bad = ~mapped | status_ro;
    wire [7:0] wbyte = pwdata[7:0];

    // Event vector; enables play no part here
    assign set_vec[`PIF_BIT_NVM] = nvm_write_done;
    assign set_vec[`PIF_BIT_LOWV] = lowv_rise;
    assign set_vec[`PIF_BIT_CRYPTO] = crypto_done;
    assign set_vec[`PIF_BIT_CMPB] = cmpb_chg & HAS_CMPB;
    assign set_vec[`PIF_BIT_CMPA] = cmpa_chg;
    assign set_vec[`PIF_BIT_OSC] = osc_rise;
    assign set_vec[1] = 1'b0;
    assign set_vec[`PIF_BIT_TIMER] = timer_wrap;

    // Software write first, then hardware sets on top of it
    assign nxt_flags = (((wr_en & hit_fl) ? wbyte : flags_ff) | set_vec) & IMPL;
    assign nxt_enable = ((wr_en & hit_en) ? wbyte : enable_ff) & IMPL;
    assign nxt_ctrl = (wr_en & hit_ct) ? (wbyte & 8'hC0) : ctrl_ff;

    // Request needs flag, enable, peripheral gate and global enable
    assign nxt_irq = (|(flags_ff & enable_ff)) & ctrl_ff[`PIF_BIT_PGATE]
        & ctrl_ff[`PIF_BIT_GIE];

    // Read mux; status shows synchronised source levels
    assign rd_byte = hit_en ? enable_ff :
                     hit_fl ? flags_ff :
                     hit_ct ? ctrl_ff :
                     hit_st ? {4'h0, cmpb_lvl & HAS_CMPB, cmpa_lvl, osc_lvl, lowv_lvl} : 8'h00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_ff <= `PIF_RST_ENABLE;
            flags_ff <= `PIF_RST_FLAGS;
            ctrl_ff <= `PIF_RST_CTRL;
            irq_ff <= 1'b0;
        end else begin
            enable_ff <= nxt_enable;
            flags_ff <= nxt_flags;
            ctrl_ff <= nxt_ctrl;
            irq_ff <= nxt_irq;
        end
    end

    // Registered bus answer; pready high in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= psel & ~penable;
            pslverr_ff <= psel & ~penable & bad;
            prdata_ff <= (psel & ~penable & ~pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign periph_irq = irq_ff;

    // Assertions
    chk_bit1_zero: assert property (@(posedge pclk) disable iff (!presetn)
        !flags_ff[1] && !enable_ff[1]) else $error("bit 1 not zero");
    chk_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
        (timer_wrap && wr_en && hit_fl && !wbyte[0]) |=> flags_ff[0]) else $error("event lost on clear");
    chk_nvm_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        (flags_ff[7] && !(wr_en && hit_fl)) |=> flags_ff[7]) else $error("nvm flag dropped");
    chk_crypto_set: assert property (@(posedge pclk) disable iff (!presetn)
        crypto_done |=> flags_ff[5]) else $error("crypto flag not set");
    chk_timer_any_en: assert property (@(posedge pclk) disable iff (!presetn)
        (timer_wrap && !enable_ff[0] && !ctrl_ff[7]) |=> flags_ff[0]) else $error("flag gated by enable");
    chk_gie_block: assert property (@(posedge pclk) disable iff (!presetn)
        !$past(ctrl_ff[7]) |-> !periph_irq) else $error("irq without global enable");
    chk_gate_block: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_ff[6] |=> !periph_irq) else $error("irq without peripheral gate");
    chk_irq_fire: assert property (@(posedge pclk) disable iff (!presetn)
        (flags_ff[0] && enable_ff[0] && ctrl_ff[7] && ctrl_ff[6]) |=> periph_irq) else $error("irq missing");
    chk_irq_mask: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_ff == 8'h00) |=> !periph_irq) else $error("irq while disabled");
    chk_osc_set: assert property (@(posedge pclk) disable iff (!presetn)
        osc_rise |=> flags_ff[2]) else $error("osc flag not set");
    chk_ready_one: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> pready) else $error("pready late");
    // Answer only in the access cycle, never outside a transfer
    chk_ready_only: assert property (@(posedge pclk) disable iff (!presetn)
        !(psel && !penable) |=> !pready) else $error("pready outside access");
    chk_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !mapped) |=> (pslverr && prdata == 32'h0000_0000)) else $error("unmapped not refused");
    chk_wr_rdata_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && pwrite) |=> (prdata == 32'h0000_0000)) else $error("read data on write");
    chk_ctrl_spare: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_ff[5:0] == 6'h00) else $error("control spare bits set");

    // Each enabled source reaches the core once both gates are open
    chk_irq_nvm: assert property (@(posedge pclk) disable iff (!presetn)
        (flags_ff[7] && enable_ff[7] && ctrl_ff[7] && ctrl_ff[6]) |=> periph_irq) else $error("nvm irq missing");
    chk_irq_lowv: assert property (@(posedge pclk) disable iff (!presetn)
        (flags_ff[6] && enable_ff[6] && ctrl_ff[7] && ctrl_ff[6]) |=> periph_irq) else $error("low supply irq missing");
    chk_irq_crypto: assert property (@(posedge pclk) disable iff (!presetn)
        (flags_ff[5] && enable_ff[5] && ctrl_ff[7] && ctrl_ff[6]) |=> periph_irq) else $error("crypto irq missing");
    chk_irq_cmpb: assert property (@(posedge pclk) disable iff (!presetn)
        (flags_ff[4] && enable_ff[4] && ctrl_ff[7] && ctrl_ff[6]) |=> periph_irq) else $error("cmp b irq missing");
    chk_irq_cmpa: assert property (@(posedge pclk) disable iff (!presetn)
        (flags_ff[3] && enable_ff[3] && ctrl_ff[7] && ctrl_ff[6]) |=> periph_irq) else $error("cmp a irq missing");
    chk_irq_osc: assert property (@(posedge pclk) disable iff (!presetn)
        (flags_ff[2] && enable_ff[2] && ctrl_ff[7] && ctrl_ff[6]) |=> periph_irq) else $error("osc irq missing");
    // Nothing pending and enabled means no request
    chk_irq_idle: assert property (@(posedge pclk) disable iff (!presetn)
        ((flags_ff & enable_ff) == 8'h00) |=> !periph_irq) else $error("irq with nothing pending");

    // Every event sets its flag on the next edge
    chk_nvm_set: assert property (@(posedge pclk) disable iff (!presetn)
        nvm_write_done |=> flags_ff[7]) else $error("nvm flag not set");
    chk_lowv_set: assert property (@(posedge pclk) disable iff (!presetn)
        lowv_rise |=> flags_ff[6]) else $error("low supply flag not set");
    chk_cmpb_set: assert property (@(posedge pclk) disable iff (!presetn)
        (cmpb_chg && HAS_CMPB) |=> flags_ff[4]) else $error("cmp b flag not set");
    chk_cmpa_set: assert property (@(posedge pclk) disable iff (!presetn)
        cmpa_chg |=> flags_ff[3]) else $error("cmp a flag not set");
    chk_timer_set: assert property (@(posedge pclk) disable iff (!presetn)
        timer_wrap |=> flags_ff[0]) else $error("timer flag not set");

    // Only a software write may drop a flag
    chk_lowv_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        (flags_ff[6] && !(wr_en && hit_fl)) |=> flags_ff[6]) else $error("low supply flag dropped");
    chk_crypto_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        (flags_ff[5] && !(wr_en && hit_fl)) |=> flags_ff[5]) else $error("crypto flag dropped");
    chk_cmpb_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        (flags_ff[4] && !(wr_en && hit_fl)) |=> flags_ff[4]) else $error("cmp b flag dropped");
    chk_cmpa_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        (flags_ff[3] && !(wr_en && hit_fl)) |=> flags_ff[3]) else $error("cmp a flag dropped");
    chk_osc_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        (flags_ff[2] && !(wr_en && hit_fl)) |=> flags_ff[2]) else $error("osc flag dropped");
    chk_timer_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        (flags_ff[0] && !(wr_en && hit_fl)) |=> flags_ff[0]) else $error("timer flag dropped");
    // Flags are set with every enable closed
    chk_nvm_any_en: assert property (@(posedge pclk) disable iff (!presetn)
        (nvm_write_done && !enable_ff[7] && !ctrl_ff[6]) |=> flags_ff[7]) else $error("nvm flag gated");

    cov_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(periph_irq));
    cov_race: cover property (@(posedge pclk) disable iff (!presetn) timer_wrap && wr_en && hit_fl);
    cov_cmpa: cover property (@(posedge pclk) disable iff (!presetn) cmpa_chg);
    cov_err: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
endmodule

// ==== src/pif_defines.svh ====
`ifndef PIF_DEFINES_SVH
`define PIF_DEFINES_SVH

// Byte addresses on the register bus
`define PIF_ADDR_ENABLE 12'h000
`define PIF_ADDR_FLAGS 12'h004
`define PIF_ADDR_CTRL 12'h008
`define PIF_ADDR_STATUS 12'h00C

// Bit positions shared by enable and flag registers
`define PIF_BIT_NVM 7
`define PIF_BIT_LOWV 6
`define PIF_BIT_CRYPTO 5
`define PIF_BIT_CMPB 4
`define PIF_BIT_CMPA 3
`define PIF_BIT_OSC 2
`define PIF_BIT_TIMER 0

// Control register fields
`define PIF_BIT_GIE 7
`define PIF_BIT_PGATE 6

// Implemented bits (bit 1 absent; bit 4 depends on variant)
`define PIF_IMPL_MASK 8'hFD
`define PIF_CMPB_MASK 8'h10

// Reset values
`define PIF_RST_ENABLE 8'h00
`define PIF_RST_FLAGS 8'h00
`define PIF_RST_CTRL 8'h00

`endif

// ==== src/pif_pkg.sv ====
package pif_pkg;
    typedef logic [7:0] pif_byte_t;
    typedef enum logic [1:0] {
        PIF_SEL_ENABLE = 2'b00,
        PIF_SEL_FLAGS = 2'b01,
        PIF_SEL_CTRL = 2'b10,
        PIF_SEL_STATUS = 2'b11
    } pif_sel_e;
endpackage

// ==== src/pif_event_sync.sv ====
`timescale 1ns/1ps
// Three-stage synchroniser for one asynchronous source
module pif_event_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic async_in,
    output logic level_out,
    output logic rise_out,
    output logic change_out
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic lvl_ff;
    logic nxt_lvl;

    // Change counts once stages two and three agree
    assign nxt_lvl = (s2_ff == s3_ff) ? s3_ff : lvl_ff;
    assign level_out = lvl_ff;
    assign rise_out = nxt_lvl & ~lvl_ff;
    assign change_out = nxt_lvl ^ lvl_ff;

    // Stage one is read only by stage two
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
            lvl_ff <= 1'b0;
        end else begin
            s1_ff <= async_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            lvl_ff <= nxt_lvl;
        end
    end
endmodule

// ==== sim/peripheral_irq_enable_flags_tb.sv ====
`timescale 1ns/1ps
`include "pif_defines.svh"
module peripheral_irq_enable_flags_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic periph_irq;
    logic nvm_write_done = 1'b0;
    logic crypto_done = 1'b0;
    logic timer_wrap = 1'b0;
    logic low_supply_detector = 1'b0;
    logic osc_fail = 1'b0;
    logic comparator_a_result = 1'b0;
    logic comparator_b_result = 1'b0;
    int n_mismatch = 0;
    int compares = 0;
    logic [31:0] seed = 32'h00000051;
    logic [31:0] rd;
    logic err;
    logic [7:0] r;

    // Free-running bus clock, 50 ns period
    always #25 pclk = ~pclk;

    pif_irq_flags #(.HAS_CMPB(1'b1)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .nvm_write_done(nvm_write_done), .crypto_done(crypto_done), .timer_wrap(timer_wrap),
        .low_supply_detector(low_supply_detector), .osc_fail(osc_fail), .comparator_a_result(comparator_a_result),
        .comparator_b_result(comparator_b_result), .periph_irq(periph_irq));

    // Repeatable pseudo-random source
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic results();
        if (n_mismatch == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; ev raises the timer event during the access cycle
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic ev,
                       output logic [31:0] q, output logic e);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        timer_wrap <= ev;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            n_mismatch++; // Hung slave ends the run
            results();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        timer_wrap <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 1'b0, rd, err);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 8'h00, 1'b0, rd, err);
        chk(rd, exp);
    endtask

    // Same-clock event pulses, one cycle wide
    task automatic pulse(input logic [7:0] m);
        @(posedge pclk);
        nvm_write_done <= m[7];
        crypto_done <= m[5];
        timer_wrap <= m[0];
        @(posedge pclk);
        nvm_write_done <= 1'b0;
        crypto_done <= 1'b0;
        timer_wrap <= 1'b0;
    endtask

    // Main sequence: reset, async sources, random events, gating, corners
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(`PIF_ADDR_ENABLE, 32'h00000000);
        rdchk(`PIF_ADDR_FLAGS, 32'h00000000);
        rdchk(`PIF_ADDR_CTRL, 32'h00000000);
        low_supply_detector <= 1'b1;
        osc_fail <= 1'b1;
        comparator_a_result <= 1'b1;
        comparator_b_result <= 1'b1;
        repeat (8) @(posedge pclk);
        rdchk(`PIF_ADDR_FLAGS, 32'h0000005C);
        rdchk(`PIF_ADDR_STATUS, 32'h0000000F);
        chk(32'(periph_irq), 32'h00000000);
        wr(`PIF_ADDR_FLAGS, 8'h00);
        low_supply_detector <= 1'b0;
        comparator_a_result <= 1'b0;
        // Long idle proves the flag is sticky, falling supply sets nothing
        repeat (20) @(posedge pclk);
        rdchk(`PIF_ADDR_FLAGS, 32'h00000008);
        rdchk(`PIF_ADDR_STATUS, 32'h0000000A);
        wr(`PIF_ADDR_CTRL, 8'hC0);
        rdchk(`PIF_ADDR_CTRL, 32'h000000C0);
        for (int n = 0; n < 12; n++) begin
            seed = xorshift(seed);
            r = seed[7:0];
            wr(`PIF_ADDR_FLAGS, 8'h00);
            wr(`PIF_ADDR_ENABLE, r);
            pulse(r);
            rdchk(`PIF_ADDR_ENABLE, {24'h000000, r & 8'hFD});
            rdchk(`PIF_ADDR_FLAGS, {24'h000000, r & 8'hA1});
            chk(32'(periph_irq), 32'(|(r & 8'hA1)));
        end
        // Every flag pending, one enable at a time
        wr(`PIF_ADDR_ENABLE, 8'h00);
        wr(`PIF_ADDR_FLAGS, 8'hFF);
        rdchk(`PIF_ADDR_FLAGS, 32'h000000FD);
        for (int i = 0; i < 8; i++) begin
            wr(`PIF_ADDR_ENABLE, 8'(8'h01 << i));
            repeat (3) @(posedge pclk);
            chk(32'(periph_irq), 32'(i != 1));
        end
        wr(`PIF_ADDR_CTRL, 8'h80);
        repeat (3) @(posedge pclk);
        chk(32'(periph_irq), 32'h00000000);
        wr(`PIF_ADDR_CTRL, 8'h40);
        repeat (3) @(posedge pclk);
        chk(32'(periph_irq), 32'h00000000);
        // Timer event lands on the same edge as the clearing write
        apb(1'b1, `PIF_ADDR_FLAGS, 8'h00, 1'b1, rd, err);
        rdchk(`PIF_ADDR_FLAGS, 32'h00000001);
        apb(1'b0, 12'h010, 8'h00, 1'b0, rd, err);
        chk(rd, 32'h00000000);
        chk(32'(err), 32'h00000001);
        apb(1'b1, `PIF_ADDR_STATUS, 8'hFF, 1'b0, rd, err);
        chk(32'(err), 32'h00000001);
        results();
    end
endmodule
